// ===== core/dlp_ctrl.sv
// self refresh and power down control of a four bank ddr sdram
`timescale 1ns/10ps
module dlp_ctrl #(
  parameter int unsigned SR_EXIT_CYCLES = dlp_pkg::SR_EXIT_DLL_CYCLES,
  parameter int unsigned SR_REF_CYCLES  = dlp_pkg::SR_REFRESH_INTERVAL
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  // command pins from the memory controller
  input  wire logic                     cke_pin,
  input  wire dlp_pkg::dlp_cmd_t        cmd_pin,
  // status toward the core array
  output logic                          in_self_refresh,
  output logic                          in_power_down,
  output logic                          int_clk_en,
  output logic                          cmd_decode_en,
  output logic                          auto_refresh_pulse,
  output logic                          self_refresh_pulse,
  output logic [dlp_pkg::ROW_W-1:0]     refresh_row,
  output logic                          cmd_ready
);
  // counters are CNT_W wide, so loads beyond that cannot be served
  if (SR_EXIT_CYCLES < 1 || SR_EXIT_CYCLES >= (1 << dlp_pkg::CNT_W)) begin : g_bad_exit
    $error("SR_EXIT_CYCLES out of range");
  end
  if (SR_REF_CYCLES < 1 || SR_REF_CYCLES >= (1 << dlp_pkg::CNT_W)) begin : g_bad_ref
    $error("SR_REF_CYCLES out of range");
  end

  localparam logic [dlp_pkg::CNT_W-1:0] SR_EXIT_LD = dlp_pkg::CNT_W'(SR_EXIT_CYCLES);
  localparam logic [dlp_pkg::CNT_W-1:0] SR_REF_LD  = dlp_pkg::CNT_W'(SR_REF_CYCLES);
  localparam logic [dlp_pkg::CNT_W-1:0] PD_EXIT_LD =
    dlp_pkg::CNT_W'(dlp_pkg::PD_EXIT_DELAY_TCK);
  localparam logic [dlp_pkg::CNT_W-1:0] CNT_ONE    = dlp_pkg::CNT_W'(1);

  // pins come from off chip, so two stages before any decode
  dlp_pkg::dlp_cmd_t cmd_s1_ff;
  dlp_pkg::dlp_cmd_t cmd_s2_ff;
  logic              cke_s1_ff;
  logic              cke_s2_ff;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmd_s1_ff <= '1;
      cmd_s2_ff <= '1;
      // idle high level, so release of reset shows no false cke fall
      cke_s1_ff <= 1'b1;
      cke_s2_ff <= 1'b1;
    end else begin
      cmd_s1_ff <= cmd_pin;
      cmd_s2_ff <= cmd_s1_ff;
      cke_s1_ff <= cke_pin;
      cke_s2_ff <= cke_s1_ff;
    end
  end

  // refresh pattern without cke; the cke level picks auto or self refresh
  function automatic logic is_refresh(input dlp_pkg::dlp_cmd_t c);
    return !c.cs_n && !c.ras_n && !c.cas_n && c.we_n;
  endfunction

  // all state but the pin synchronizer stages in one packed word, next value built by the process below
  dlp_pkg::dlp_state_t st_ff;
  dlp_pkg::dlp_state_t nxt_st;

  // row pointer step, shared by auto and internal refresh
  function automatic logic [dlp_pkg::ROW_W-1:0] row_next(
    input logic [dlp_pkg::ROW_W-1:0] r
  );
    return r + 1'b1;
  endfunction

  function automatic logic [dlp_pkg::CNT_W-1:0] cnt_dec(
    input logic [dlp_pkg::CNT_W-1:0] c
  );
    return c - 1'b1;
  endfunction

  // last cycle of a count; zero is taken as an end too, never a wrap
  function automatic logic cnt_last(input logic [dlp_pkg::CNT_W-1:0] c);
    return c <= CNT_ONE;
  endfunction

  // exit delay step: commands stay held off until the count runs out
  function automatic dlp_pkg::dlp_state_t exit_tick(input dlp_pkg::dlp_state_t s);
    dlp_pkg::dlp_state_t n;
    n          = s;
    n.exit_cnt = cnt_dec(s.exit_cnt);
    n.ready    = cnt_last(s.exit_cnt);
    return n;
  endfunction

  // self refresh: core clock gated, receivers off, internal timer started
  function automatic dlp_pkg::dlp_state_t go_self_refresh(input dlp_pkg::dlp_state_t s);
    dlp_pkg::dlp_state_t n;
    n            = s;
    n.mode       = dlp_pkg::DLP_SELF_REFRESH;
    n.sr_flag    = 1'b1;
    n.int_clk_en = 1'b0;
    n.cmd_enable = 1'b0;
    n.ready      = 1'b0;
    n.ref_cnt    = SR_REF_LD;
    return n;
  endfunction

  // power down keeps the core clock, only the command path goes quiet
  function automatic dlp_pkg::dlp_state_t go_power_down(input dlp_pkg::dlp_state_t s);
    dlp_pkg::dlp_state_t n;
    n            = s;
    n.mode       = dlp_pkg::DLP_POWER_DOWN;
    n.pd_flag    = 1'b1;
    n.cmd_enable = 1'b0;
    n.ready      = 1'b0;
    return n;
  endfunction

  // the exit count covers dll relock before commands are taken again
  function automatic dlp_pkg::dlp_state_t leave_self_refresh(input dlp_pkg::dlp_state_t s);
    dlp_pkg::dlp_state_t n;
    n            = s;
    n.mode       = dlp_pkg::DLP_ACTIVE;
    n.sr_flag    = 1'b0;
    n.int_clk_en = 1'b1;
    n.cmd_enable = 1'b1;
    n.exit_cnt   = SR_EXIT_LD;
    return n;
  endfunction

  function automatic dlp_pkg::dlp_state_t leave_power_down(input dlp_pkg::dlp_state_t s);
    dlp_pkg::dlp_state_t n;
    n            = s;
    n.mode       = dlp_pkg::DLP_ACTIVE;
    n.pd_flag    = 1'b0;
    n.cmd_enable = 1'b1;
    n.exit_cnt   = PD_EXIT_LD;
    return n;
  endfunction

  // one internal refresh per interval; power down has no such timer
  function automatic dlp_pkg::dlp_state_t self_refresh_tick(input dlp_pkg::dlp_state_t s);
    dlp_pkg::dlp_state_t n;
    n                = s;
    n.ref_cnt        = SR_REF_LD;
    n.self_ref_pulse = 1'b1;
    n.ref_row        = row_next(s.ref_row);
    return n;
  endfunction

  always_comb begin
    nxt_st                = st_ff;
    nxt_st.cke_q          = cke_s2_ff;
    nxt_st.auto_ref_pulse = 1'b0;
    nxt_st.self_ref_pulse = 1'b0;
    case (st_ff.mode)
      dlp_pkg::DLP_ACTIVE: begin
        if (st_ff.exit_cnt != dlp_pkg::CNT_RST) begin
          nxt_st = exit_tick(nxt_st);
        end
        // the refresh pattern with cke low wins over plain power down
        if (!cke_s2_ff && is_refresh(cmd_s2_ff)) begin
          nxt_st = go_self_refresh(nxt_st);
        end else if (!cke_s2_ff) begin
          nxt_st = go_power_down(nxt_st);
        end else if (st_ff.cke_q && st_ff.ready && is_refresh(cmd_s2_ff)) begin
          // cke high on both edges selects auto refresh over self refresh
          nxt_st.auto_ref_pulse = 1'b1;
          nxt_st.ref_row        = row_next(st_ff.ref_row);
        end
      end
      dlp_pkg::DLP_SELF_REFRESH: begin
        // command pins are not looked at here, only cke
        if (cke_s2_ff) begin
          nxt_st = leave_self_refresh(nxt_st);
        end else if (cnt_last(st_ff.ref_cnt)) begin
          nxt_st = self_refresh_tick(nxt_st);
        end else begin
          nxt_st.ref_cnt = cnt_dec(st_ff.ref_cnt);
        end
      end
      dlp_pkg::DLP_POWER_DOWN: begin
        if (cke_s2_ff) begin
          nxt_st = leave_power_down(nxt_st);
        end
      end
      default: begin
        nxt_st.mode    = dlp_pkg::DLP_ACTIVE;
        nxt_st.sr_flag = 1'b0;
        nxt_st.pd_flag = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff.cke_q          <= 1'b1;
      st_ff.mode           <= dlp_pkg::DLP_ACTIVE;
      st_ff.exit_cnt       <= dlp_pkg::CNT_RST;
      st_ff.ref_cnt        <= dlp_pkg::CNT_RST;
      st_ff.ref_row        <= dlp_pkg::ROW_RST;
      st_ff.int_clk_en     <= 1'b1;
      st_ff.cmd_enable     <= 1'b1;
      st_ff.auto_ref_pulse <= 1'b0;
      st_ff.self_ref_pulse <= 1'b0;
      st_ff.ready          <= 1'b1;
      st_ff.sr_flag        <= 1'b0;
      st_ff.pd_flag        <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs, each straight from the state register
  assign in_self_refresh    = st_ff.sr_flag;
  assign in_power_down      = st_ff.pd_flag;
  assign int_clk_en         = st_ff.int_clk_en;
  assign cmd_decode_en      = st_ff.cmd_enable;
  assign auto_refresh_pulse = st_ff.auto_ref_pulse;
  assign self_refresh_pulse = st_ff.self_ref_pulse;
  assign refresh_row        = st_ff.ref_row;
  assign cmd_ready          = st_ff.ready;
endmodule

// ===== core/dlp_pkg.sv
// package for the ddr low power control block: constants and carried types
package dlp_pkg;
  localparam int unsigned CLK_PERIOD_PS        = 4000;
  localparam int unsigned SR_EXIT_DLL_CYCLES   = 200;
  localparam int unsigned PD_ENTRY_DELAY_TCK   = 1;
  localparam int unsigned PD_EXIT_DELAY_TCK    = 1;
  localparam int unsigned REFRESH_PERIOD_MS    = 64;
  localparam int unsigned REFRESH_ROWS         = 4096;
  localparam int unsigned REFRESH_PERIOD_CYC   =
    (REFRESH_PERIOD_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned SR_REFRESH_INTERVAL  = REFRESH_PERIOD_CYC / REFRESH_ROWS;
  localparam int unsigned CNT_W                = 16;
  localparam int unsigned ROW_W                = 12;
  localparam logic [ROW_W-1:0] ROW_RST         = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RST         = 16'h0000;

  typedef enum logic [1:0] {
    DLP_ACTIVE,
    DLP_SELF_REFRESH,
    DLP_POWER_DOWN
  } dlp_mode_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dlp_cmd_t;

  typedef struct packed {
    logic            cke_q;
    dlp_mode_t       mode;
    logic [CNT_W-1:0] exit_cnt;
    logic [CNT_W-1:0] ref_cnt;
    logic [ROW_W-1:0] ref_row;
    logic            int_clk_en;
    logic            cmd_enable;
    logic            auto_ref_pulse;
    logic            self_ref_pulse;
    logic            ready;
    logic            sr_flag;
    logic            pd_flag;
  } dlp_state_t;
endpackage

// ===== test/dlp_ctrl_sva.sv
// port assertions for the ddr low power control block
`timescale 1ns/10ps
module dlp_ctrl_sva #(
  parameter int unsigned SR_EXIT_CYCLES = dlp_pkg::SR_EXIT_DLL_CYCLES
) (
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      nrst,
  // pins
  input wire logic                      cke_pin,
  input wire dlp_pkg::dlp_cmd_t         cmd_pin,
  // status
  input wire logic                      in_self_refresh,
  input wire logic                      in_power_down,
  input wire logic                      int_clk_en,
  input wire logic                      cmd_decode_en,
  input wire logic                      auto_refresh_pulse,
  input wire logic                      self_refresh_pulse,
  input wire logic [dlp_pkg::ROW_W-1:0] refresh_row,
  input wire logic                      cmd_ready
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // three high cycles first so a stale low cke cannot mean power down
  sequence s_sr_cmd;
    cke_pin[*3] ##1 !cke_pin && cmd_pin == 4'h1 && !in_power_down && cmd_ready;
  endsequence
  sequence s_aref;
    cke_pin && cmd_pin == 4'h1 ##1 (cke_pin && cmd_ready)[*2];
  endsequence
  sequence s_pd_cmd;
    cke_pin[*3] ##1 !cke_pin && cmd_pin == 4'h7 && cmd_ready;
  endsequence
  a_sr_entry_seen: assert property (s_sr_cmd |-> ##3 in_self_refresh)
    else $error("self refresh not entered");
  a_sr_clk_off: assert property (in_self_refresh |-> !int_clk_en && !cmd_decode_en)
    else $error("clock or decode live in self refresh");
  a_sr_no_cmd: assert property (in_self_refresh |-> !auto_refresh_pulse && !in_power_down)
    else $error("command acted on in self refresh");
  a_pd_rx_off: assert property (in_power_down |-> !cmd_decode_en && !auto_refresh_pulse)
    else $error("receivers live in power down");
  a_pd_entry_seen: assert property (s_pd_cmd |-> ##3 in_power_down)
    else $error("power down not entered");
  a_sr_pulse_own: assert property (self_refresh_pulse |-> in_self_refresh)
    else $error("internal refresh outside self refresh");
  a_row_advance: assert property ((auto_refresh_pulse || self_refresh_pulse)
    |-> refresh_row == $past(refresh_row) + 12'h001)
    else $error("refresh row did not advance");
  a_aref_taken: assert property (s_aref |-> ##1 auto_refresh_pulse)
    else $error("auto refresh not decoded");
  a_sr_exit_wait: assert property ($fell(in_self_refresh)
    |-> !cmd_ready ##SR_EXIT_CYCLES cmd_ready)
    else $error("self refresh exit delay wrong");
  a_pd_exit_wait: assert property ($fell(in_power_down) |-> !cmd_ready ##1 cmd_ready)
    else $error("power down exit delay wrong");
endmodule
bind dlp_ctrl dlp_ctrl_sva #(.SR_EXIT_CYCLES(SR_EXIT_CYCLES)) u_sva (
  .sys_clk(sys_clk), .nrst(nrst), .cke_pin(cke_pin), .cmd_pin(cmd_pin),
  .in_self_refresh(in_self_refresh), .in_power_down(in_power_down),
  .int_clk_en(int_clk_en), .cmd_decode_en(cmd_decode_en),
  .auto_refresh_pulse(auto_refresh_pulse), .self_refresh_pulse(self_refresh_pulse),
  .refresh_row(refresh_row), .cmd_ready(cmd_ready));

// ===== test/dlp_mc_model.sv
// memory controller model on the clock enable and command pins
`timescale 1ns/10ps
module dlp_mc_model (
  // clock
  input  wire logic         sys_clk,
  // pins toward the device
  output dlp_pkg::dlp_cmd_t cmd,
  output logic              cke
);
  initial begin
    cke = 1'b1;
    cmd = 4'hF;
  end
  task automatic put(input logic k, input logic [3:0] c);
    @(negedge sys_clk);
    cke = k;
    cmd = c;
  endtask
  // 10 clocks of 4 ns keep the row open 40 ns; 5 clocks cover precharge
  localparam int ROW_OPEN_CYC = 10;
  localparam int ROW_REST_CYC = 5;
  task automatic row_cycle();
    put(1'b1, 4'h3);
    repeat (ROW_OPEN_CYC) put(1'b1, 4'hF);
    put(1'b1, 4'h2);
    repeat (ROW_REST_CYC) put(1'b1, 4'hF);
  endtask
  // banks are taken as precharged and idle before each refresh
  task automatic aref();
    put(1'b1, 4'h1);
    put(1'b1, 4'hF);
  endtask
  task automatic sr_enter();
    aref();
    put(1'b0, 4'h1);
  endtask
  // cke stays low while pins toggle every cycle
  task automatic junk(input int n);
    for (int i = 0; i < n; i++)
      put(1'b0, i[0] ? 4'h1 : 4'h6);
  endtask
  task automatic wake();
    put(1'b0, 4'hF);
    put(1'b1, 4'hF);
  endtask
  task automatic pd_enter();
    put(1'b0, 4'h7);
  endtask
endmodule

// ===== test/tb_dlp_ctrl.sv
// self-checking bench for the ddr low power control block
`timescale 1ns/10ps
module tb_dlp_ctrl;
  localparam int unsigned EXIT_N = 4;
  logic                      sys_clk = 1'b0;
  logic                      nrst = 1'b0;
  dlp_pkg::dlp_cmd_t         cmd;
  logic                      cke, in_sr, in_pd, clk_en, dec_en, ar_p, sr_p, ready;
  logic [dlp_pkg::ROW_W-1:0] row;
  int                        error_cnt = 0, num_checks = 0, ar_n = 0, sr_n = 0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ar_n <= ar_n + ar_p;
    sr_n <= sr_n + sr_p;
  end
  dlp_mc_model mc (.sys_clk(sys_clk), .cmd(cmd), .cke(cke));
  dlp_ctrl #(.SR_EXIT_CYCLES(EXIT_N), .SR_REF_CYCLES(5)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .cke_pin(cke), .cmd_pin(cmd),
    .in_self_refresh(in_sr), .in_power_down(in_pd), .int_clk_en(clk_en),
    .cmd_decode_en(dec_en), .auto_refresh_pulse(ar_p), .self_refresh_pulse(sr_p),
    .refresh_row(row), .cmd_ready(ready));
  task automatic check(input string what, input logic [11:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic t_aref();
    int a0;
    a0 = ar_n;
    mc.row_cycle();
    check("act pre", 12'(ar_n - a0), 12'h000);
    mc.aref();
    wait_n(4);
    check("aref", 12'(ar_n - a0), 12'h001);
    check("row", row, 12'(ar_n + sr_n));
  endtask
  task automatic t_sr();
    int a0, s0;
    mc.sr_enter();
    wait_n(4);
    check("sr", {in_sr, clk_en, dec_en, ready}, 12'h008);
    a0 = ar_n;
    s0 = sr_n;
    mc.junk(12);
    check("sr cmd", 12'(ar_n - a0), 12'h000);
    check("sr ref", 12'(sr_n - s0 >= 2), 12'h001);
    mc.wake();
    wait_n(3);
    check("sr exit", {in_sr, clk_en, dec_en, ready}, 12'h006);
    wait_n(EXIT_N - 1);
    check("sr wait", ready, 12'h000);
    wait_n(1);
    check("sr ready", ready, 12'h001);
  endtask
  task automatic t_pd();
    int a0;
    mc.pd_enter();
    wait_n(4);
    check("pd", {in_sr, in_pd, dec_en, ready}, 12'h004);
    a0 = ar_n;
    mc.junk(6);
    check("pd cmd", 12'(ar_n - a0) | {in_sr, 11'h000}, 12'h000);
    mc.wake();
    wait_n(3);
    check("pd exit", {in_pd, dec_en, ready}, 12'h002);
    wait_n(1);
    check("pd ready", ready, 12'h001);
  endtask
  initial begin
    wait_n(3);
    nrst = 1'b1;
    wait_n(4);
    t_aref();
    t_sr();
    t_aref();
    t_pd();
    t_aref();
    print_verdict();
  end
  // whole run is near 120 cycles; the limit allows 1000
  initial begin
    #4000;
    error_cnt++;
    print_verdict();
  end
endmodule
